// ---- design/arg_pkg.sv ----
// shared constants for the analog ramp generator
package arg_pkg;

  // clock and timing
  localparam int unsigned ARG_CLK_PERIOD_NS = 50;
  localparam int unsigned ARG_TICK_TIME_MS = 100;
  localparam int unsigned ARG_TICK_CYCLES_DEF =
    ARG_TICK_TIME_MS * 1000000 / ARG_CLK_PERIOD_NS;

  // data widths
  localparam int unsigned ARG_VW = 16;
  localparam int unsigned ARG_LW = 18;
  localparam int unsigned ARG_DW = 32;
  localparam int unsigned ARG_AW = 6;

  // value ranges
  localparam logic signed [ARG_LW-1:0] ARG_LEVEL_MIN = -18'sd10000;
  localparam logic signed [ARG_LW-1:0] ARG_LEVEL_MAX = 18'sd20000;
  localparam logic signed [ARG_LW-1:0] ARG_SSO_MIN = 18'sd0;
  localparam logic signed [ARG_LW-1:0] ARG_RATE_MIN = 18'sd1;
  localparam logic signed [ARG_LW-1:0] ARG_RATE_MAX = 18'sd10000;
  localparam logic signed [ARG_LW-1:0] ARG_GAIN_MIN = 18'sd0;
  localparam logic signed [ARG_LW-1:0] ARG_GAIN_MAX = 18'sd1000;
  localparam logic signed [ARG_LW-1:0] ARG_BASE_MIN = -18'sd10000;
  localparam logic signed [ARG_LW-1:0] ARG_BASE_MAX = 18'sd10000;
  localparam logic [ARG_VW-1:0] ARG_OUT_MAX = 16'h7FFF;
  localparam logic signed [ARG_LW-1:0] ARG_GAIN_UNIT = 18'sd100;
  localparam logic [ARG_LW-1:0] ARG_RATE_DIV = 18'd10;

  // register byte addresses
  localparam logic [ARG_AW-1:0] ARG_REG_FIRST = 6'h00;
  localparam logic [ARG_AW-1:0] ARG_REG_SECOND = 6'h04;
  localparam logic [ARG_AW-1:0] ARG_REG_CEIL = 6'h08;
  localparam logic [ARG_AW-1:0] ARG_REG_SSO = 6'h0C;
  localparam logic [ARG_AW-1:0] ARG_REG_RATE = 6'h10;
  localparam logic [ARG_AW-1:0] ARG_REG_GAIN = 6'h14;
  localparam logic [ARG_AW-1:0] ARG_REG_BASE = 6'h18;
  localparam logic [ARG_AW-1:0] ARG_REG_DEC = 6'h1C;
  localparam logic [ARG_AW-1:0] ARG_REG_SRC = 6'h20;
  localparam logic [ARG_AW-1:0] ARG_REG_STATUS = 6'h24;
  localparam logic [ARG_AW-1:0] ARG_REG_OUT = 6'h28;

  // source select fields
  localparam int unsigned ARG_SRC_IDX_W = 5;
  localparam int unsigned ARG_SRC1_IDX_LSB = 0;
  localparam int unsigned ARG_SRC1_LIVE_BIT = 7;
  localparam int unsigned ARG_SRC2_IDX_LSB = 8;
  localparam int unsigned ARG_SRC2_LIVE_BIT = 15;
  // status fields
  localparam int unsigned ARG_ST_STATE_LSB = 0;
  localparam int unsigned ARG_ST_LEVEL_LSB = 16;

  // reset values
  localparam logic signed [ARG_LW-1:0] ARG_RST_CEIL = 18'sd20000;
  localparam logic signed [ARG_LW-1:0] ARG_RST_RATE = 18'sd100;
  localparam logic signed [ARG_LW-1:0] ARG_RST_GAIN = 18'sd100;
  localparam logic signed [ARG_LW-1:0] ARG_RST_ZERO = 18'sd0;

  typedef enum logic [2:0] {
    ARG_IDLE,
    ARG_START_HOLD,
    ARG_RAMP,
    ARG_STOP_RAMP,
    ARG_STOP_HOLD,
    ARG_LOCKED
  } arg_state_t;

endpackage : arg_pkg

// ---- design/arg_ramp_gen.sv ----
// analog ramp generator: timed ramp of a level toward selectable targets
// Behaviour
// - on enable rising, level is start/stop offset plus base for 100 ms
// - then level ramps from start/stop level to selected target at the rate
// - decelerated stop ramps level back to start/stop level at the rate
// - start/stop level held 100 ms after stop, then level set to base
// - after a stop, no restart until both stop and enable are low
// - changing select ramps from present target to new target at the rate
// - enable low sets the level to base at once, no ramping
// - level is recomputed once per 100 ms tick
// - output is level minus base, times 100, divided by gain
// - decimal places only stored for display, never used in computation
// - each target may come live from another function by block number
// - select 0 picks first target, select 1 picks second target
// - level never exceeds the programmed ceiling
// - targets and ceiling -10000..20000, rate 1..10000 steps per second
module arg_ramp_gen
  import arg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = ARG_TICK_CYCLES_DEF,
  parameter int unsigned NUM_SRC = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic level_sel_i,
  input wire logic decel_stop_i,
  input wire logic [NUM_SRC-1:0][ARG_VW-1:0] src_value_i,
  input wire logic [ARG_AW-1:0] reg_addr_i,
  input wire logic [ARG_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [ARG_DW-1:0] reg_rdata_o,
  output logic [ARG_VW-1:0] scaled_analog_out_o,
  output logic ramp_active_o
);

  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

  initial begin
    if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
    if (NUM_SRC < 1 || NUM_SRC > (1 << ARG_SRC_IDX_W)) $error("NUM_SRC out of range");
  end

  function automatic logic signed [ARG_LW-1:0] clamp(input logic signed [ARG_LW-1:0] v,
      input logic signed [ARG_LW-1:0] lo, input logic signed [ARG_LW-1:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction : clamp

  function automatic logic signed [ARG_LW-1:0] wr_val(input logic [ARG_DW-1:0] d);
    return ARG_LW'(signed'(d[ARG_VW-1:0]));
  endfunction : wr_val

  function automatic logic signed [ARG_LW-1:0] pick_src(input logic live,
      input logic [ARG_SRC_IDX_W-1:0] idx, input logic signed [ARG_LW-1:0] fixed,
      input logic [NUM_SRC-1:0][ARG_VW-1:0] vals);
    logic signed [ARG_LW-1:0] v;
    v = fixed;
    // an index past the last source falls back to the constant
    if (live && 32'(idx) < NUM_SRC) begin
      v = clamp(ARG_LW'(signed'(vals[idx])), ARG_LEVEL_MIN, ARG_LEVEL_MAX);
    end
    return v;
  endfunction : pick_src

  // pin synchronisers: change counted once stages two and three agree
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_lvl;
  logic en_lvl;
  logic sel_lvl;
  logic stop_lvl;
  logic en_prev;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pin_lvl <= 3'h0;
      en_prev <= 1'b0;
    end else begin
      pin_s1 <= {decel_stop_i, level_sel_i, enable_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 3; i++) begin
        if (pin_s2[i] == pin_s3[i]) pin_lvl[i] <= pin_s3[i];
      end
      en_prev <= pin_lvl[0];
    end
  end

  assign en_lvl = pin_lvl[0];
  assign sel_lvl = pin_lvl[1];
  assign stop_lvl = pin_lvl[2];

  // parameter registers
  logic signed [ARG_LW-1:0] first_target_level;
  logic signed [ARG_LW-1:0] second_target_level;
  logic signed [ARG_LW-1:0] level_ceiling;
  logic signed [ARG_LW-1:0] start_stop_offset;
  logic signed [ARG_LW-1:0] rate;
  logic signed [ARG_LW-1:0] gain;
  logic signed [ARG_LW-1:0] base_offset;
  logic [1:0] decimals;
  logic [ARG_VW-1:0] src_sel;

  // out-of-range writes are clamped into range rather than dropped
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      first_target_level <= ARG_RST_ZERO;
      second_target_level <= ARG_RST_ZERO;
      level_ceiling <= ARG_RST_CEIL;
      start_stop_offset <= ARG_RST_ZERO;
      rate <= ARG_RST_RATE;
      gain <= ARG_RST_GAIN;
      base_offset <= ARG_RST_ZERO;
      decimals <= 2'h0;
      src_sel <= 16'h0000;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        ARG_REG_FIRST: first_target_level <= clamp(wr_val(reg_wdata_i), ARG_LEVEL_MIN, ARG_LEVEL_MAX);
        ARG_REG_SECOND: second_target_level <= clamp(wr_val(reg_wdata_i), ARG_LEVEL_MIN, ARG_LEVEL_MAX);
        ARG_REG_CEIL: level_ceiling <= clamp(wr_val(reg_wdata_i), ARG_LEVEL_MIN, ARG_LEVEL_MAX);
        ARG_REG_SSO: start_stop_offset <= clamp(wr_val(reg_wdata_i), ARG_SSO_MIN, ARG_LEVEL_MAX);
        ARG_REG_RATE: rate <= clamp(wr_val(reg_wdata_i), ARG_RATE_MIN, ARG_RATE_MAX);
        ARG_REG_GAIN: gain <= clamp(wr_val(reg_wdata_i), ARG_GAIN_MIN, ARG_GAIN_MAX);
        ARG_REG_BASE: base_offset <= clamp(wr_val(reg_wdata_i), ARG_BASE_MIN, ARG_BASE_MAX);
        ARG_REG_DEC: decimals <= reg_wdata_i[1:0];
        ARG_REG_SRC: src_sel <= reg_wdata_i[ARG_VW-1:0];
        default: ;
      endcase
    end
  end

  // target selection
  logic signed [ARG_LW-1:0] tgt1;
  logic signed [ARG_LW-1:0] tgt2;
  logic signed [ARG_LW-1:0] target;
  logic signed [ARG_LW-1:0] ss_level;

  assign tgt1 = pick_src(src_sel[ARG_SRC1_LIVE_BIT], src_sel[ARG_SRC1_IDX_LSB +: ARG_SRC_IDX_W],
    first_target_level, src_value_i);
  assign tgt2 = pick_src(src_sel[ARG_SRC2_LIVE_BIT], src_sel[ARG_SRC2_IDX_LSB +: ARG_SRC_IDX_W],
    second_target_level, src_value_i);
  assign target = sel_lvl ? tgt2 : tgt1;
  assign ss_level = start_stop_offset + base_offset;

  // tick and hold timer: restarted on entry to a hold so each hold is a full tick
  arg_state_t state;
  logic [CW-1:0] tick_cnt;
  logic tick;
  logic restart_cnt;

  assign tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_cnt || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + CW'(1);
    end
  end

  // step per tick: a tenth of rate, fraction carried so slow rates still move
  logic [3:0] frac;
  logic [ARG_LW-1:0] acc_sum;
  logic signed [ARG_LW-1:0] step;

  assign acc_sum = ARG_LW'(frac) + ARG_LW'(rate);
  assign step = signed'(acc_sum / ARG_RATE_DIV);

  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_cnt) begin
      frac <= 4'h0;
    end else if (tick) begin
      frac <= 4'(acc_sum % ARG_RATE_DIV);
    end
  end

  function automatic logic signed [ARG_LW-1:0] approach(input logic signed [ARG_LW-1:0] cur,
      input logic signed [ARG_LW-1:0] tgt, input logic signed [ARG_LW-1:0] stp);
    if (cur < tgt) return (tgt - cur > stp) ? cur + stp : tgt;
    if (cur > tgt) return (cur - tgt > stp) ? cur - stp : tgt;
    return cur;
  endfunction : approach

  // state and level
  arg_state_t next_state;
  logic signed [ARG_LW-1:0] level;
  logic signed [ARG_LW-1:0] next_level;
  logic signed [ARG_LW-1:0] raw_level;

  always_comb begin
    next_state = state;
    raw_level = level;
    restart_cnt = 1'b0;
    if (!en_lvl) begin
      raw_level = base_offset;
      if (state != ARG_LOCKED || !stop_lvl) next_state = ARG_IDLE;
    end else begin
      unique case (state)
        ARG_IDLE: begin
          raw_level = base_offset;
          if (!en_prev) begin
            next_state = ARG_START_HOLD;
            raw_level = ss_level;
            restart_cnt = 1'b1;
          end
        end
        ARG_START_HOLD: begin
          raw_level = ss_level;
          if (stop_lvl) next_state = ARG_STOP_RAMP;
          else if (tick) next_state = ARG_RAMP;
        end
        ARG_RAMP: begin
          if (stop_lvl) next_state = ARG_STOP_RAMP;
          else if (tick) raw_level = approach(level, target, step);
        end
        ARG_STOP_RAMP: begin
          if (level == ss_level || level < ss_level && level == level_ceiling) begin
            next_state = ARG_STOP_HOLD;
            restart_cnt = 1'b1;
          end else if (tick) begin
            raw_level = approach(level, ss_level, step);
          end
        end
        ARG_STOP_HOLD: begin
          if (tick) begin
            raw_level = base_offset;
            next_state = ARG_LOCKED;
          end
        end
        ARG_LOCKED: raw_level = base_offset;
      endcase
    end
    next_level = (raw_level > level_ceiling) ? level_ceiling : raw_level;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= ARG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      level <= ARG_RST_ZERO;
    end else begin
      level <= next_level;
    end
  end

  // scaled output; zero gain saturates rather than dividing by zero
  function automatic logic [ARG_VW-1:0] scale(input logic signed [ARG_LW-1:0] lvl,
      input logic signed [ARG_LW-1:0] b, input logic signed [ARG_LW-1:0] g);
    logic signed [ARG_LW-1:0] diff;
    logic [ARG_DW-1:0] q;
    diff = lvl - b;
    q = '0;
    if (diff <= 0) return '0;
    if (g == 0) return ARG_OUT_MAX;
    q = (ARG_DW'(diff) * ARG_DW'(ARG_GAIN_UNIT)) / ARG_DW'(g);
    return (q > ARG_DW'(ARG_OUT_MAX)) ? ARG_OUT_MAX : q[ARG_VW-1:0];
  endfunction : scale

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      scaled_analog_out_o <= '0;
      ramp_active_o <= 1'b0;
    end else begin
      scaled_analog_out_o <= scale(level, base_offset, gain);
      ramp_active_o <= (state != ARG_IDLE) && (state != ARG_LOCKED);
    end
  end

  // register read port: data in the cycle after the strobe only
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !reg_rd_i) begin
      reg_rdata_o <= '0;
    end else begin
      unique case (reg_addr_i)
        ARG_REG_FIRST: reg_rdata_o <= ARG_DW'(first_target_level);
        ARG_REG_SECOND: reg_rdata_o <= ARG_DW'(second_target_level);
        ARG_REG_CEIL: reg_rdata_o <= ARG_DW'(level_ceiling);
        ARG_REG_SSO: reg_rdata_o <= ARG_DW'(start_stop_offset);
        ARG_REG_RATE: reg_rdata_o <= ARG_DW'(rate);
        ARG_REG_GAIN: reg_rdata_o <= ARG_DW'(gain);
        ARG_REG_BASE: reg_rdata_o <= ARG_DW'(base_offset);
        ARG_REG_DEC: reg_rdata_o <= ARG_DW'(decimals);
        ARG_REG_SRC: reg_rdata_o <= ARG_DW'(src_sel);
        ARG_REG_STATUS: begin
          reg_rdata_o <= '0;
          reg_rdata_o[ARG_ST_STATE_LSB +: 3] <= state;
          reg_rdata_o[ARG_ST_LEVEL_LSB +: ARG_VW] <= level[ARG_VW-1:0];
        end
        ARG_REG_OUT: reg_rdata_o <= ARG_DW'(scaled_analog_out_o);
        default: reg_rdata_o <= '0;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stop_hold_end;
    state == ARG_STOP_HOLD && tick && en_lvl;
  endsequence

  sequence s_dropped_to_base;
    state == ARG_LOCKED && (level == $past(base_offset) ||
      $past(base_offset) > $past(level_ceiling) && level == $past(level_ceiling));
  endsequence

  chk_start_level: assert property (
    state == ARG_START_HOLD |-> level == $past(ss_level) ||
      $past(ss_level) > $past(level_ceiling) && level == $past(level_ceiling))
    else $error("start hold level wrong");

  chk_start_hold_len: assert property (
    state == ARG_START_HOLD && !tick && en_lvl && !stop_lvl |=> state == ARG_START_HOLD)
    else $error("start hold ended early");

  chk_ramp_rises: assert property (
    state == ARG_RAMP && tick && en_lvl && !stop_lvl && level < target
    && level < level_ceiling && step != 0 |=> level > $past(level))
    else $error("ramp did not move toward target");
  chk_stop_falls: assert property (
    state == ARG_STOP_RAMP && tick && en_lvl && level > ss_level && level < level_ceiling
    && step != 0 |=> level < $past(level))
    else $error("stop ramp did not fall");

  chk_stop_drop: assert property (
    s_stop_hold_end |=> s_dropped_to_base)
    else $error("stop hold did not drop to base");

  chk_lock_holds: assert property (
    state == ARG_LOCKED && stop_lvl |=> state == ARG_LOCKED)
    else $error("restart before inputs cleared");

  chk_disable_base: assert property (
    !en_lvl |=> level == $past(base_offset) ||
      $past(base_offset) > $past(level_ceiling) && level == $past(level_ceiling))
    else $error("disable did not set base level");

  chk_tick_only: assert property (
    state == ARG_RAMP && !tick && en_lvl && !stop_lvl ##1 state == ARG_RAMP
    |-> $stable(level) || level == $past(level_ceiling))
    else $error("level moved between ticks");

  chk_no_overshoot: assert property (
    state == ARG_RAMP && tick && en_lvl && !stop_lvl && level <= target
    |=> level <= $past(target))
    else $error("ramp overshot target");

  chk_level_ceiling: assert property (
    1'b1 |=> level <= $past(level_ceiling))
    else $error("level above ceiling");

endmodule : arg_ramp_gen

// ---- tb/arg_ctrl_model.sv ----
// control-program model driving the ramp generator's enable, select and stop pins
module arg_ctrl_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic run_req_i,
  input wire logic sel_req_i,
  input wire logic stop_req_i,
  output logic enable_o,
  output logic level_sel_o,
  output logic decel_stop_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stopped;
  // a stop stays latched until both pins are seen low
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stopped <= 1'h0;
    end else if (decel_stop_o) begin
      stopped <= 1'h1;
    end else if (!enable_o) begin
      stopped <= 1'h0;
    end
  end
  // enable may fall at any time but only rises once the stop has been cleared
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      enable_o <= 1'h0;
      level_sel_o <= 1'h0;
      decel_stop_o <= 1'h0;
    end else begin
      enable_o <= run_req_i && (enable_o || !stopped);
      level_sel_o <= sel_req_i;
      decel_stop_o <= stop_req_i;
    end
  end
endmodule : arg_ctrl_model

// ---- tb/test_analog_ramp_generator.sv ----
// self-checking bench for the analog ramp generator
module test_analog_ramp_generator
  import arg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TICKS = 20;
  logic core_clk_i, rst_i, run_req, sel_req, stop_req, enable, level_sel, decel_stop;
  logic [7:0][ARG_VW-1:0] src_value;
  logic [ARG_AW-1:0] reg_addr;
  logic [ARG_DW-1:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, ramp_active, rd_seen;
  logic [ARG_VW-1:0] scaled_out;
  logic [ARG_DW-1:0] exp_q[$];
  logic signed [15:0] tgt1;
  int n_fail, samples_checked, seed;
  logic [ARG_AW-1:0] ra [12] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C,
    6'h20, 6'h24, 6'h28, 6'h2C};
  logic [ARG_DW-1:0] rv [12] = '{32'h0, 32'h0, 32'h4E20, 32'h0, 32'h64, 32'h64, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0};

  arg_ctrl_model arg_ctrl_model_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .run_req_i(run_req), .sel_req_i(sel_req), .stop_req_i(stop_req), .enable_o(enable),
    .level_sel_o(level_sel), .decel_stop_o(decel_stop));

  arg_ramp_gen #(.TICK_CYCLES(TICKS), .NUM_SRC(8)) arg_ramp_gen_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .enable_i(enable), .level_sel_i(level_sel), .decel_stop_i(decel_stop),
    .src_value_i(src_value), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .scaled_analog_out_o(scaled_out), .ramp_active_o(ramp_active));

  initial begin
    core_clk_i = 1'h0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    samples_checked++;
    if (got !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk_i);
    reg_wr <= 1'h0;
  endtask : wr

  // expected read data is noted when the read is launched
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_rd <= 1'h1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    reg_rd <= 1'h0;
  endtask : rd

  task automatic st(input logic [2:0] s, input logic signed [15:0] l);
    rd(ARG_REG_STATUS, {l, 13'h0, s});
  endtask : st

  task automatic outc(input logic [15:0] o);
    rd(ARG_REG_OUT, {16'h0, o});
    chk("scaled_out", {16'h0, o}, {16'h0, scaled_out});
  endtask : outc

  task automatic final_report;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // read data stands only in the cycle after the strobe; sample mid-cycle
  always @(posedge core_clk_i) rd_seen <= reg_rd & ~rst_i;
  always @(negedge core_clk_i) begin
    if (rd_seen === 1'h1) begin
      chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
  end

  initial begin
    cyc(20000);
    n_fail++;
    $display("mismatch watchdog expected done seen timeout");
    final_report();
  end

  initial begin
    seed = 32'hBC4B;
    rst_i = 1'h1;
    {run_req, sel_req, stop_req, reg_wr, reg_rd, rd_seen} = 6'h0;
    reg_addr = '0;
    reg_wdata = '0;
    n_fail = 0;
    samples_checked = 0;
    for (int i = 0; i < 8; i++) begin
      src_value[i] = 16'($random(seed));
    end
    cyc(8);
    rst_i <= 1'h0;
    for (int i = 0; i < 12; i++) begin
      rd(ra[i], rv[i]);
    end
    wr(ARG_REG_STATUS, 32'hFFFF);
    rd(ARG_REG_STATUS, 32'h0);
    wr(ARG_REG_FIRST, 32'hFFFFB1E0);
    rd(ARG_REG_FIRST, 32'hFFFFD8F0);
    wr(ARG_REG_RATE, 32'h4E20);
    rd(ARG_REG_RATE, 32'h2710);
    wr(ARG_REG_BASE, 32'h64);
    wr(ARG_REG_SSO, 32'h32);
    wr(ARG_REG_RATE, 32'h64);
    wr(ARG_REG_GAIN, 32'h32);
    wr(ARG_REG_DEC, {30'h0, 2'($random(seed))});
    wr(ARG_REG_SECOND, 32'hC8);
    // odd targets make the last step land short of a full tenth of the rate
    tgt1 = 16'sh96 + {8'h0, 8'($random(seed))};
    wr(ARG_REG_FIRST, {16'h0, tgt1});
    run_req <= 1'h1;
    cyc(6);
    st(ARG_START_HOLD, 16'h96);
    chk("ramp_active", 32'h1, {31'h0, ramp_active});
    cyc(8);
    st(ARG_START_HOLD, 16'h96);
    cyc(TICKS * 30);
    st(ARG_RAMP, tgt1);
    outc(16'(2 * (tgt1 - 16'sh64)));
    sel_req <= 1'h1;
    cyc(TICKS * 25);
    st(ARG_RAMP, 16'hC8);
    wr(ARG_REG_CEIL, 32'hB4);
    cyc(TICKS * 3);
    st(ARG_RAMP, 16'hB4);
    wr(ARG_REG_CEIL, 32'h4E20);
    wr(ARG_REG_SRC, 32'h83);
    src_value[3] <= 16'h104;
    sel_req <= 1'h0;
    cyc(TICKS * 12);
    st(ARG_RAMP, 16'h104);
    outc(16'h140);
    stop_req <= 1'h1;
    cyc(TICKS * 16);
    st(ARG_LOCKED, 16'h64);
    outc(16'h0);
    chk("ramp_active", 32'h0, {31'h0, ramp_active});
    stop_req <= 1'h0;
    cyc(TICKS * 2);
    st(ARG_LOCKED, 16'h64);
    run_req <= 1'h0;
    cyc(8);
    run_req <= 1'h1;
    cyc(6);
    st(ARG_START_HOLD, 16'h96);
    cyc(TICKS * 4);
    run_req <= 1'h0;
    cyc(6);
    st(ARG_IDLE, 16'h64);
    outc(16'h0);
    cyc(4);
    final_report();
  end
endmodule : test_analog_ramp_generator
